//--- eodc_defs.vh
`ifndef EODC_DEFS_VH
`define EODC_DEFS_VH
// ----------------------------------------------------------------------------
// Shared constants of the emulation output-disable control block.
// ----------------------------------------------------------------------------
`define EODC_LVL_HIGH      1'h1
`define EODC_LVL_LOW       1'h0
`define EODC_SYNC_DEPTH    2
`define EODC_NUM_OUTS      16
`define EODC_ZERO_OUTS     16'h0000
`define EODC_MODE_FUNC     1'h0
`define EODC_MODE_SCAN     1'h1
`endif

//--- eodc_sync.v
`timescale 1ns/100ps
// ----------------------------------------------------------------------------
// Two-flip-flop synchroniser for one level from outside the clock domain.
// ----------------------------------------------------------------------------
`include "eodc_defs.vh"
module eodc_sync (
  input  wire clk,
  input  wire rst,
  input  wire asyncIn,
  output reg  syncOut
);
  reg stageOne_reg;

  // The first stage feeds only the second stage, to contain metastability.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      stageOne_reg <= `EODC_LVL_LOW;
      syncOut      <= `EODC_LVL_LOW;
    end else begin
      stageOne_reg <= asyncIn;
      syncOut      <= stageOne_reg;
    end
  end
endmodule // eodc_sync

//--- eodc_emulation_output_disable_ctrl.v
`timescale 1ns/100ps
`include "eodc_defs.vh"
module eodc_emulation_output_disable_ctrl (
  input  wire                       clk,
  input  wire                       rst,
  input  wire                       testResetPin,
  input  wire                       testClockPin,
  input  wire                       testModeSelPin,
  input  wire                       testDataInPin,
  input  wire                       scanDataOut,
  input  wire                       scanPinADirOut,
  input  wire                       scanPinBDirOut,
  input  wire                       scanPinAOut,
  input  wire                       scanPinBOut,
  input  wire                       emulator_pin_a_in,
  input  wire                       emulator_pin_b_output_disable_in,
  input  wire [`EODC_NUM_OUTS-1:0]  coreOutEnable,
  output reg                        emulator_pin_a_out,
  output reg                        emulator_pin_a_oe,
  output reg                        emulator_pin_b_output_disable_out,
  output reg                        emulator_pin_b_output_disable_oe,
  output reg                        emuIntFromPinA,
  output reg                        emuIntFromPinB,
  output reg                        scanModeActive,
  output reg                        testModeSelSample,
  output reg                        testDataInSample,
  output reg                        testSampleStrobe,
  output reg                        testDataOut,
  output reg                        testDataOutOe,
  output reg                        outputDisableActive,
  output reg [`EODC_NUM_OUTS-1:0]   deviceOutEnable
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  wire testResetSync;
  wire testClockSync;
  wire tmsSync;
  wire tdiSync;
  wire pinASync;
  wire pinBSync;

  eodc_sync uSyncTrst (.clk(clk), .rst(rst), .asyncIn(testResetPin), .syncOut(testResetSync));
  eodc_sync uSyncTck  (.clk(clk), .rst(rst), .asyncIn(testClockPin), .syncOut(testClockSync));
  eodc_sync uSyncTms  (.clk(clk), .rst(rst), .asyncIn(testModeSelPin), .syncOut(tmsSync));
  eodc_sync uSyncTdi  (.clk(clk), .rst(rst), .asyncIn(testDataInPin), .syncOut(tdiSync));
  eodc_sync uSyncPinA (.clk(clk), .rst(rst), .asyncIn(emulator_pin_a_in), .syncOut(pinASync));
  eodc_sync uSyncPinB (.clk(clk), .rst(rst),
                       .asyncIn(emulator_pin_b_output_disable_in), .syncOut(pinBSync));

  // --------------------------------------------------------------------------
  // Test clock edge detection
  // --------------------------------------------------------------------------
  reg  testClockPrev_reg;
  wire tckRise;
  wire tckFall;

  // Edges are found on the synchronised copy, never on the first stage.
  // The reset level matches the idle low test clock, so no false edge follows.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      testClockPrev_reg <= `EODC_LVL_LOW;
    end else begin
      testClockPrev_reg <= testClockSync;
    end
  end
  assign tckRise = testClockSync & ~testClockPrev_reg;
  assign tckFall = ~testClockSync & testClockPrev_reg;

  // --------------------------------------------------------------------------
  // Mode and output-disable decode
  // --------------------------------------------------------------------------
  wire scanMode;
  wire offCondition;

  // An unconnected test reset is pulled low, so functional mode is the default.
  assign scanMode     = (testResetSync == `EODC_MODE_SCAN);
  // All three terms must hold; no state is kept, so release follows at once.
  assign offCondition = ~scanMode & (pinASync == `EODC_LVL_HIGH)
                        & (pinBSync == `EODC_LVL_LOW);

  // --------------------------------------------------------------------------
  // Next values of the mode and disable outputs
  // --------------------------------------------------------------------------
  reg                      scanModeActive_next;
  reg                      outputDisableActive_next;
  reg [`EODC_NUM_OUTS-1:0] deviceOutEnable_next;

  // The disable is a plain gate on the core enables and keeps no state of its
  // own, so the drivers come back on the first cycle after any term fails.
  always @* begin
    scanModeActive_next      = scanMode;
    outputDisableActive_next = offCondition;
    deviceOutEnable_next     = coreOutEnable;
    if (offCondition) begin
      deviceOutEnable_next = `EODC_ZERO_OUTS;
    end
  end

  // Registering the outputs keeps the ports glitch free at the price of one
  // cycle, which is small against the rate at which the pins can change.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      scanModeActive      <= `EODC_MODE_FUNC;
      outputDisableActive <= `EODC_LVL_LOW;
      deviceOutEnable     <= `EODC_ZERO_OUTS;
    end else begin
      scanModeActive      <= scanModeActive_next;
      outputDisableActive <= outputDisableActive_next;
      deviceOutEnable     <= deviceOutEnable_next;
    end
  end

  // --------------------------------------------------------------------------
  // Direction decode shared by both emulator pins
  // --------------------------------------------------------------------------
  // A pin is driven only in scan mode, and only when scan has chosen output.
  function pinDrives;
    input modeScan;
    input dirOut;
    begin
      pinDrives = modeScan & (dirOut == `EODC_LVL_HIGH);
    end
  endfunction

  // An incoming interrupt is passed on only in scan mode, from a pin set as input.
  function pinListens;
    input modeScan;
    input dirOut;
    input level;
    begin
      pinListens = modeScan & (dirOut == `EODC_LVL_LOW) & level;
    end
  endfunction

  // --------------------------------------------------------------------------
  // Emulator pins
  // --------------------------------------------------------------------------
  reg pinAOut_next;
  reg pinAOe_next;
  reg pinAInt_next;
  reg pinBOut_next;
  reg pinBOe_next;
  reg pinBInt_next;

  // Pin A is a scan-steered interrupt line in scan mode and an input otherwise.
  // The disable also blocks its drive; the two cannot meet, as the disable
  // needs functional mode, but the gate keeps the override complete.
  always @* begin
    pinAOut_next = scanPinAOut;
    pinAOe_next  = pinDrives(scanMode, scanPinADirOut) & ~offCondition;
    pinAInt_next = pinListens(scanMode, scanPinADirOut, pinASync);
  end

  // Pin B is never driven in functional mode, where it is the disable input.
  always @* begin
    pinBOut_next = scanPinBOut;
    pinBOe_next  = pinDrives(scanMode, scanPinBDirOut);
    pinBInt_next = pinListens(scanMode, scanPinBDirOut, pinBSync);
  end

  // The pin drivers and interrupt levels are registered like every other output.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      emulator_pin_a_out                <= `EODC_LVL_LOW;
      emulator_pin_a_oe                 <= `EODC_LVL_LOW;
      emuIntFromPinA                    <= `EODC_LVL_LOW;
      emulator_pin_b_output_disable_out <= `EODC_LVL_LOW;
      emulator_pin_b_output_disable_oe  <= `EODC_LVL_LOW;
      emuIntFromPinB                    <= `EODC_LVL_LOW;
    end else begin
      emulator_pin_a_out                <= pinAOut_next;
      emulator_pin_a_oe                 <= pinAOe_next;
      emuIntFromPinA                    <= pinAInt_next;
      emulator_pin_b_output_disable_out <= pinBOut_next;
      emulator_pin_b_output_disable_oe  <= pinBOe_next;
      emuIntFromPinB                    <= pinBInt_next;
    end
  end

  // --------------------------------------------------------------------------
  // Test access port sampling and data out
  // --------------------------------------------------------------------------
  reg tmsSample_next;
  reg tdiSample_next;
  reg strobe_next;
  reg tdo_next;
  reg tdoOe_next;

  // Test inputs are ignored in functional mode, so a test clock there leaves the
  // samples and the data output as they were. Samples hold until the next rise.
  always @* begin
    strobe_next    = tckRise & scanMode;
    tmsSample_next = testModeSelSample;
    tdiSample_next = testDataInSample;
    tdo_next       = testDataOut;
    tdoOe_next     = scanMode & ~offCondition;
    if (strobe_next) begin
      tmsSample_next = tmsSync;
      tdiSample_next = tdiSync;
    end
    if (tckFall && scanMode) begin
      tdo_next = scanDataOut;
    end
  end

  // The strobe stands for one cycle; a user that needs the data output in step
  // with the pin must allow for the three cycles of synchroniser and register.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      testModeSelSample <= `EODC_LVL_LOW;
      testDataInSample  <= `EODC_LVL_LOW;
      testSampleStrobe  <= `EODC_LVL_LOW;
      testDataOut       <= `EODC_LVL_LOW;
      testDataOutOe     <= `EODC_LVL_LOW;
    end else begin
      testModeSelSample <= tmsSample_next;
      testDataInSample  <= tdiSample_next;
      testSampleStrobe  <= strobe_next;
      testDataOut       <= tdo_next;
      testDataOutOe     <= tdoOe_next;
    end
  end
endmodule // eodc_emulation_output_disable_ctrl

//--- eodc_chk_asserts.sv
`timescale 1ns/100ps
module eodc_chk (
  input wire        clk,
  input wire        rst,
  input wire        testResetPin,
  input wire        emulator_pin_a_in,
  input wire        emulator_pin_b_output_disable_in,
  input wire        scanPinBDirOut,
  input wire        scanPinBOut,
  input wire [15:0] coreOutEnable,
  input wire        emulator_pin_b_output_disable_out,
  input wire        emulator_pin_b_output_disable_oe,
  input wire        scanModeActive,
  input wire        testSampleStrobe,
  input wire        testDataOutOe,
  input wire        outputDisableActive,
  input wire [15:0] deviceOutEnable
);
  // --------------------------------------------------------------------------
  // Clocking and the pin-level disable term
  // --------------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Five cycles cover two sync flops, the output register and the first edge after reset.
  wire offCond = !testResetPin && emulator_pin_a_in && !emulator_pin_b_output_disable_in;
  sequence offHeld; offCond [*5]; endsequence
  sequence offGone; !offCond [*5]; endsequence
  AST_OFF_SET: assert property (offHeld |-> outputDisableActive && deviceOutEnable == 16'h0000)
    else $error("outputs not floated");
  AST_TDO_OFF: assert property (offHeld |-> !testDataOutOe) else $error("data out driven");
  AST_OFF_REL: assert property (offGone |-> !outputDisableActive) else $error("disable stuck");
  AST_PASS: assert property ((!offCond && $stable(coreOutEnable)) [*5] |-> deviceOutEnable == coreOutEnable)
    else $error("enable not passed");
  AST_DIS_ZERO: assert property (outputDisableActive |-> deviceOutEnable == 16'h0000) else $error("enable leak");
  AST_SCAN: assert property (testResetPin [*5] |-> scanModeActive) else $error("scan not taken");
  AST_FUNC: assert property ((!testResetPin) [*5] |-> !scanModeActive && !emulator_pin_b_output_disable_oe
    && !testSampleStrobe) else $error("scan leak");
  AST_PULSE: assert property (testSampleStrobe |=> !testSampleStrobe) else $error("strobe long");
  AST_PINB: assert property ((testResetPin && scanPinBDirOut && $stable(scanPinBOut)) [*5]
    |-> emulator_pin_b_output_disable_oe && emulator_pin_b_output_disable_out == scanPinBOut) else $error("pin b");
endmodule // eodc_chk

//--- eodc_emu_model.sv
`timescale 1ns/100ps
module eodc_emu_model (
  input  wire  go,
  input  wire  tmsBit,
  input  wire  tdiBit,
  output logic tck,
  output logic tms,
  output logic tdi
);
  initial begin
    {tck, tms, tdi} = 3'b000;
  end
  // One test clock period per request; the clock stands low between frames.
  // Its edges fall between the block's clock edges, so sampling never races them.
  always @(posedge go) begin
    tms <= tmsBit;
    tdi <= tdiBit;
    #410 tck = 1'b1;
    #400 tck = 1'b0;
  end
endmodule // eodc_emu_model

//--- testbench.sv
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; $display("FAIL %0t %h %h", $time, a, b); end end
module testbench;
  logic clk = 0, rst = 1, trst = 0, pa = 0, pb = 1, dirA = 0, dirB = 0, aOut = 0, bOut = 0, go = 0, tmsB = 0, tdiB = 0;
  logic [15:0] core = 16'h0000, devOe;
  logic sdo = 0;
  wire aO, aE, bO, bE, intA, intB, scan, tmsS, tdiS, tdoE, dis, tck, tms, tdi, tdo;
  // Pin levels resolve from the block's enable and the emulator's own drive.
  wire aLvl = aE ? aO : pa;
  wire bLvl = bE ? bO : pb;
  int fails = 0, compares = 0;
  eodc_emu_model eodc_emu_model_inst (.go(go), .tmsBit(tmsB), .tdiBit(tdiB), .tck(tck), .tms(tms), .tdi(tdi));
  eodc_emulation_output_disable_ctrl eodc_emulation_output_disable_ctrl_inst (.clk(clk), .rst(rst),
    .testResetPin(trst), .testClockPin(tck), .testModeSelPin(tms), .testDataInPin(tdi), .scanDataOut(sdo),
    .scanPinADirOut(dirA), .scanPinBDirOut(dirB), .scanPinAOut(aOut), .scanPinBOut(bOut),
    .emulator_pin_a_in(aLvl), .emulator_pin_b_output_disable_in(bLvl), .coreOutEnable(core),
    .emulator_pin_a_out(aO), .emulator_pin_a_oe(aE), .emulator_pin_b_output_disable_out(bO),
    .emulator_pin_b_output_disable_oe(bE), .emuIntFromPinA(intA), .emuIntFromPinB(intB), .scanModeActive(scan),
    .testModeSelSample(tmsS), .testDataInSample(tdiS), .testSampleStrobe(), .testDataOut(tdo), .testDataOutOe(tdoE),
    .outputDisableActive(dis), .deviceOutEnable(devOe));
  task wt(input int n); begin repeat (n) @(posedge clk); #1; end endtask
  task end_sim; begin
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  end endtask
  // The disable condition is entered only here, as a test of the drivers.
  task t_off; begin
    @(posedge clk);
    pb <= 0;
    core <= 16'hffff;
    wt(5);
    `CHK(dis, 1'h0)
    `CHK(devOe, 16'hffff)
    @(posedge clk);
    pa <= 1;
    wt(5);
    `CHK(devOe, 16'h0000)
    `CHK(dis, 1'h1)
    `CHK(tdoE, 1'h0)
    @(posedge clk);
    pb <= 1;
    wt(5);
    `CHK(devOe, 16'hffff)
    `CHK(dis, 1'h0)
    $display("test off done");
  end endtask
  task t_scan; begin
    @(posedge clk);
    trst <= 1;
    dirA <= 1;
    aOut <= 1;
    wt(5);
    `CHK(scan, 1'h1)
    `CHK({aE, aO, bE}, 3'h6)
    `CHK(intB, 1'h1)
    `CHK(tdoE, 1'h1)
    @(posedge clk);
    dirA <= 0;
    dirB <= 1;
    bOut <= 1;
    wt(5);
    `CHK({bE, bO}, 2'h3)
    `CHK({aE, intA, intB}, 3'h2)
    $display("test scan done");
  end endtask
  task t_shift; begin
    @(posedge clk);
    tmsB <= 1;
    tdiB <= 0;
    sdo <= 1;
    go <= 1;
    wt(8);
    `CHK({tmsS, tdiS}, 2'h2)
    `CHK(tdo, 1'h0)
    wt(6);
    `CHK(tdo, 1'h1)
    @(posedge clk);
    go <= 0;
    trst <= 0;
    wt(5);
    `CHK(scan, 1'h0)
    @(posedge clk);
    tmsB <= 0;
    tdiB <= 1;
    sdo <= 0;
    go <= 1;
    wt(14);
    `CHK({tmsS, tdiS, tdo}, 3'h5)
    $display("test shift done");
  end endtask
  initial begin
    forever #50 clk = ~clk;
  end
  initial begin
    #100000; fails++; end_sim;
  end
  initial begin
    repeat (3) @(posedge clk); rst <= 0;
    t_off; t_scan; t_shift; end_sim;
  end
endmodule // testbench
bind eodc_emulation_output_disable_ctrl eodc_chk eodc_chk_inst (.clk, .rst, .testResetPin, .emulator_pin_a_in,
  .emulator_pin_b_output_disable_in, .scanPinBDirOut, .scanPinBOut, .coreOutEnable, .emulator_pin_b_output_disable_out,
  .emulator_pin_b_output_disable_oe, .scanModeActive, .testSampleStrobe, .testDataOutOe, .outputDisableActive,
  .deviceOutEnable);
